// ---- logic/ecc_addr_latch.sv ----
// address phase latch of the multiplexed host bus
`timescale 1ns/10ps
`default_nettype none
module ecc_addr_latch
    import ecc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic addr_latch_strobe,
    input wire logic [7:0] ad_in,
    input wire logic cs_n,
    output ecc_addr_type addr_q,
    output logic selected
);
    logic [2:0] as_sync_q;
    logic [8:0] ad_s1_q;
    logic [8:0] ad_s2_q;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            as_sync_q <= 3'h0;
            ad_s1_q <= 9'h100;
            ad_s2_q <= 9'h100;
        end
        else
        begin
            as_sync_q <= {as_sync_q[1:0], addr_latch_strobe};
            ad_s1_q <= {cs_n, ad_in};
            ad_s2_q <= ad_s1_q;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            addr_q <= '{cs_n: 1'b1, default: '0};
        end
        else if (as_sync_q[2] && !as_sync_q[1])
        begin
            addr_q <= ecc_addr_type'(ad_s2_q);
        end
    end

    // select on nibble and chip select
    assign selected = (addr_q.auto_select_nibble == SELECT_NIB) && !addr_q.cs_n;
endmodule : ecc_addr_latch
`default_nettype wire

// ---- logic/ecc_core.sv ----
// eighty-column code packing, transfer and attribute processing
//
// Function
// - two code formats, long twelve bit and short eight bit, selectable.
// - short format reaches only the 128 glyph base alphanumeric set; long also reaches mosaics.
// - long code is character byte plus nibble; bit seven selects set.
// - set bit zero: low seven bits pick an alphanumeric glyph, six columns.
// - alphanumeric nibble bits are four independent attributes.
// - mosaic: nibble bits 1-3 and char bits 0-6 drive sub-windows.
// - mosaic nibble bit zero is colour select.
// - short code with bit seven clear equals long code with zero nibble; with bit seven set it stays alphanumeric.
// - long codes paired in three bytes; row uses 120 bytes.
// - even code in first buffer, odd in second, nibbles in third.
// - short codes use same placement without nibble buffer, 80 bytes.
// - nibble transfer moves 12 bits, read-modify-writes nibble, auto-increments.
// - byte transfer does same sequential transfer for short codes.
// - short codes and mosaics never flash or take the negative swap; only the underline cursor underlines them.
// - attributes applied: underline, flash, colour select, negative, insert.
// - underline forces foreground on slice nine.
// - flash forces background at half hertz, phase from negative.
// - colour select: margin background, foreground from origin register.
// - negative swaps colours; complemented cursor complements them.
// - insert value chosen by dual select, applied per insert mode.
// - falling address strobe latches bus lines and chip select.
// - address bits: index, execution request, auto-select nibble, chip select.
// - selected only when nibble is two and latched select is zero.
`timescale 1ns/10ps
`default_nettype none
module ecc_core
    import ecc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic addr_latch_strobe,
    input wire logic [7:0] ad_in,
    input wire logic cs_n,
    output ecc_addr_type latched_addr,
    output logic chip_selected,
    input wire logic long_mode,
    input wire logic nibble_code_transfer_cmd,
    input wire logic byte_code_transfer_cmd,
    input wire logic xfer_write,
    input wire logic auto_inc,
    input wire logic [ADDR_W-1:0] pos_in,
    input wire logic pos_load,
    input wire logic [CHAR_W-1:0] data_reg_first,
    input wire logic [CHAR_W-1:0] data_reg_third,
    output logic [CHAR_W-1:0] rd_first_q,
    output logic [CHAR_W-1:0] rd_third_q,
    output logic xfer_busy,
    output logic xfer_done,
    output logic [ADDR_W-1:0] pos_q,
    input wire logic [CHAR_W-1:0] disp_char,
    input wire logic [NIB_W-1:0] disp_attr,
    input wire logic [3:0] slice_index,
    input wire logic [2:0] pixel_col,
    input wire logic glyph_bit,
    input wire logic ul_cursor,
    input wire logic comp_cursor,
    input wire logic insert_mode,
    input wire ecc_origin_type char_set_origin_reg,
    input wire logic [COLOR_W-1:0] margin_color,
    input wire logic [COLOR_W-1:0] base_fg,
    input wire logic [COLOR_W-1:0] base_bg,
    output logic [6:0] glyph_index_q,
    output logic [COLOR_W-1:0] pixel_color_q
);
    // ----------------------------------------
    // address phase
    // ----------------------------------------
    ecc_addr_latch u_addr
    (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .addr_latch_strobe(addr_latch_strobe),
        .ad_in(ad_in),
        .cs_n(cs_n),
        .addr_q(latched_addr),
        .selected(chip_selected)
    );

    // ----------------------------------------
    // packing address functions
    // ----------------------------------------
    function automatic logic [ADDR_W-1:0] char_addr(input logic [ADDR_W-1:0] pos);
        // even in first, odd in second
        char_addr = (pos[0] ? BUF2_BASE : 7'h00) + {1'b0, pos[ADDR_W-1:1]};
    endfunction : char_addr

    function automatic logic [ADDR_W-1:0] nib_addr(input logic [ADDR_W-1:0] pos);
        nib_addr = BUF3_BASE + {1'b0, pos[ADDR_W-1:1]};
    endfunction : nib_addr

    // ----------------------------------------
    // transfer sequencer
    // ----------------------------------------
    typedef enum logic [2:0] {ST_IDLE, ST_RD_CHAR, ST_RD_NIB, ST_WAIT, ST_WR_NIB, ST_END}
        ecc_state_type;
    ecc_state_type state_q;
    logic is_nib_q;
    logic wr_q;
    logic mem_we;
    logic [ADDR_W-1:0] mem_waddr;
    logic [CHAR_W-1:0] mem_wdata;
    logic [ADDR_W-1:0] mem_raddr;
    logic [CHAR_W-1:0] mem_rdata;

    ecc_row_mem u_mem
    (
        .ref_clk(ref_clk),
        .wr_en(mem_we),
        .wr_addr(mem_waddr),
        .wr_data(mem_wdata),
        .rd_addr(mem_raddr),
        .rd_data(mem_rdata)
    );

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= ST_IDLE;
            is_nib_q <= 1'b0;
            wr_q <= 1'b0;
        end
        else
        begin
            unique case (state_q)
                ST_IDLE:
                begin
                    if (nibble_code_transfer_cmd && long_mode)
                    begin
                        is_nib_q <= 1'b1;
                        wr_q <= xfer_write;
                        state_q <= ST_RD_CHAR;
                    end
                    else if (byte_code_transfer_cmd)
                    begin
                        is_nib_q <= 1'b0;
                        wr_q <= xfer_write;
                        state_q <= ST_RD_CHAR;
                    end
                end
                ST_RD_CHAR: state_q <= is_nib_q ? ST_RD_NIB : ST_WAIT;
                ST_RD_NIB: state_q <= ST_WAIT;
                ST_WAIT: state_q <= (is_nib_q && wr_q) ? ST_WR_NIB : ST_END;
                ST_WR_NIB: state_q <= ST_END;
                ST_END: state_q <= ST_IDLE;
            endcase
        end
    end

    assign xfer_busy = (state_q != ST_IDLE);
    assign xfer_done = (state_q == ST_END);
    assign mem_raddr = (state_q == ST_RD_CHAR) ? char_addr(pos_q) : nib_addr(pos_q);

    always_comb
    begin
        mem_we = 1'b0;
        mem_waddr = char_addr(pos_q);
        mem_wdata = data_reg_first;
        if (state_q == ST_RD_CHAR && wr_q)
        begin
            mem_we = 1'b1;
        end
        else if (state_q == ST_WR_NIB)
        begin
            mem_we = 1'b1;
            mem_waddr = nib_addr(pos_q);
            mem_wdata = pos_q[0] ? {data_reg_third[NIB_W-1:0], mem_rdata[NIB_W-1:0]}
                                 : {mem_rdata[CHAR_W-1:NIB_W], data_reg_third[NIB_W-1:0]};
        end
    end

    // read data returned to data registers
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_first_q <= 8'h00;
            rd_third_q <= 8'h00;
        end
        else if (!wr_q)
        begin
            if (state_q == ST_RD_NIB)
            begin
                rd_first_q <= mem_rdata;
            end
            else if (state_q == ST_WAIT && is_nib_q)
            begin
                rd_third_q <= {4'h0, pos_q[0] ? mem_rdata[CHAR_W-1:NIB_W]
                                              : mem_rdata[NIB_W-1:0]};
            end
            else if (state_q == ST_WAIT)
            begin
                rd_first_q <= mem_rdata;
                rd_third_q <= {4'h0, SHORT_NIB};
            end
        end
    end

    // position wraps at row end for both formats
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pos_q <= 7'h00;
        end
        else if (pos_load && !xfer_busy)
        begin
            pos_q <= pos_in;
        end
        else if (xfer_done && auto_inc)
        begin
            pos_q <= (pos_q == POS_LAST) ? 7'h00 : pos_q + 7'h01;
        end
    end

    // ----------------------------------------
    // flash timebase
    // ----------------------------------------
    logic [24:0] flash_cnt_q;
    logic flash_phase_q;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flash_cnt_q <= 25'h0;
            flash_phase_q <= 1'b0;
        end
        else if (flash_cnt_q == 25'(FLASH_HALF_CYC - 1))
        begin
            flash_cnt_q <= 25'h0;
            flash_phase_q <= ~flash_phase_q;
        end
        else
        begin
            flash_cnt_q <= flash_cnt_q + 25'h1;
        end
    end

    // ----------------------------------------
    // cell decode and attribute chain
    // ----------------------------------------
    ecc_code_type code;
    logic mosaic;
    logic fg_on;
    logic [1:0] sub_col;
    logic [2:0] sub_row;
    logic [6:0] glyph_idx;
    logic [COLOR_W-1:0] fg;
    logic [COLOR_W-1:0] bg;
    logic [COLOR_W-1:0] tmp;
    logic [COLOR_W-1:0] pix;
    logic [9:0] mosaic_bits;

    always_comb
    begin
        code.chr = disp_char;
        code.attr = long_mode ? disp_attr : SHORT_NIB;
        mosaic = long_mode && code.chr[SET_BIT];
        glyph_idx = code.chr[6:0];
        mosaic_bits = {code.attr[3:1], code.chr[6:0]};
        sub_col = (pixel_col < 3'(SUB_W)) ? 2'h0 : 2'h1;
        sub_row = 3'(slice_index[3:1]);
        fg_on = mosaic ? mosaic_bits[{sub_row, 1'b0} + 4'(sub_col)] : glyph_bit;
        fg = base_fg;
        bg = base_bg;
        if (((!mosaic && code.attr[ATT_UNDERLINE]) || ul_cursor) && slice_index == LAST_SLICE)
        begin
            fg_on = 1'b1;
        end
        if (!mosaic && code.attr[ATT_FLASH] && (flash_phase_q ^ code.attr[ATT_NEGATIVE]))
        begin
            fg_on = 1'b0;
        end
        if (mosaic && code.attr[ATT_COLSEL])
        begin
            bg = margin_color;
            fg = code.chr[6] ? char_set_origin_reg.fg_b : char_set_origin_reg.fg_a;
        end
        if (comp_cursor)
        begin
            fg = ~fg;
            bg = ~bg;
        end
        else if (!mosaic && code.attr[ATT_NEGATIVE])
        begin
            tmp = fg;
            fg = bg;
            bg = tmp;
        end
        else
        begin
            tmp = fg;
        end
        pix = fg_on ? fg : bg;
        if (insert_mode && !mosaic)
        begin
            pix = code.attr[ATT_DUAL] ? char_set_origin_reg.ins_b : char_set_origin_reg.ins_a;
        end
        tmp = pix;
    end

    // registered cell outputs
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            glyph_index_q <= 7'h00;
            pixel_color_q <= 4'h0;
        end
        else
        begin
            glyph_index_q <= glyph_idx;
            pixel_color_q <= tmp;
        end
    end
endmodule : ecc_core
`default_nettype wire

// ---- logic/ecc_pkg.sv ----
// package for the eighty-column character code and attribute block
package ecc_pkg;
    // code fields
    localparam int unsigned CODE_W = 12;
    localparam int unsigned CHAR_W = 8;
    localparam int unsigned NIB_W = 4;
    localparam int unsigned SET_BIT = 7;
    localparam logic [NIB_W-1:0] SHORT_NIB = 4'h0;
    // attribute nibble bit positions (alphanumeric; ATT_COLSEL is the mosaic colour select)
    localparam int unsigned ATT_UNDERLINE = 0;
    localparam int unsigned ATT_FLASH = 1;
    localparam int unsigned ATT_NEGATIVE = 2;
    localparam int unsigned ATT_DUAL = 3;
    localparam int unsigned ATT_COLSEL = 0;
    // cell geometry
    localparam int unsigned CELL_W = 6;
    localparam int unsigned CELL_H = 10;
    localparam logic [3:0] LAST_SLICE = 4'h9;
    localparam int unsigned SUB_W = 3;
    localparam int unsigned SUB_H = 2;
    // row buffers
    localparam int unsigned ROW_CODES = 80;
    localparam int unsigned HALF_ROW = 40;
    localparam int unsigned LONG_ROW_BYTES = 120;
    localparam int unsigned SHORT_ROW_BYTES = 80;
    localparam int unsigned ADDR_W = 7;
    localparam logic [ADDR_W-1:0] BUF2_BASE = 7'h28;
    localparam logic [ADDR_W-1:0] BUF3_BASE = 7'h50;
    localparam logic [ADDR_W-1:0] POS_LAST = 7'h4f;
    // flash timing
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned FLASH_HALF_MS = 1000;
    localparam int unsigned FLASH_HALF_CYC = CLK_HZ / 1000 * FLASH_HALF_MS;
    // address phase
    localparam logic [3:0] SELECT_NIB = 4'h2;
    localparam int unsigned COLOR_W = 4;
    typedef struct packed {
        logic cs_n;
        logic [3:0] auto_select_nibble;
        logic exec_request_bit;
        logic [2:0] reg_index;
    } ecc_addr_type;
    typedef struct packed {
        logic [NIB_W-1:0] attr;
        logic [CHAR_W-1:0] chr;
    } ecc_code_type;
    typedef struct packed {
        logic [COLOR_W-1:0] fg_a;
        logic [COLOR_W-1:0] fg_b;
        logic [COLOR_W-1:0] ins_a;
        logic [COLOR_W-1:0] ins_b;
    } ecc_origin_type;
endpackage : ecc_pkg

// ---- logic/ecc_row_mem.sv ----
// row buffer memory with registered read data
`timescale 1ns/10ps
`default_nettype none
module ecc_row_mem
    import ecc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic wr_en,
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic [CHAR_W-1:0] wr_data,
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic [CHAR_W-1:0] rd_data
);
    logic [CHAR_W-1:0] mem_q [LONG_ROW_BYTES];

    always_ff @(posedge ref_clk)
    begin
        if (wr_en)
        begin
            mem_q[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        rd_data <= mem_q[rd_addr];
    end
endmodule : ecc_row_mem
`default_nettype wire

// ---- verif/ecc_core_assertions.sv ----
// checker for the eighty-column code block ports
`timescale 1ns/10ps
`default_nettype none
module ecc_core_assertions
    import ecc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic addr_latch_strobe,
    input wire logic [7:0] ad_in,
    input wire logic cs_n,
    input wire ecc_addr_type latched_addr,
    input wire logic chip_selected,
    input wire logic long_mode,
    input wire logic nibble_code_transfer_cmd,
    input wire logic byte_code_transfer_cmd,
    input wire logic xfer_write,
    input wire logic auto_inc,
    input wire logic pos_load,
    input wire logic xfer_busy,
    input wire logic xfer_done,
    input wire logic [ADDR_W-1:0] pos_q,
    input wire logic [CHAR_W-1:0] disp_char,
    input wire logic [NIB_W-1:0] disp_attr,
    input wire logic [3:0] slice_index,
    input wire logic [2:0] pixel_col,
    input wire logic glyph_bit,
    input wire logic ul_cursor,
    input wire logic comp_cursor,
    input wire logic insert_mode,
    input wire logic [COLOR_W-1:0] base_fg,
    input wire logic [COLOR_W-1:0] base_bg,
    input wire logic [6:0] glyph_index_q,
    input wire logic [COLOR_W-1:0] pixel_color_q
);
    // ----------------------------------------
    // helpers and properties
    // ----------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    logic [9:0] sub;
    logic [3:0] idx;
    logic nib_go;
    logic byte_go;
    logic plain;
    logic [COLOR_W-1:0] plain_c;
    logic [COLOR_W-1:0] neg_c;
    logic [COLOR_W-1:0] mos_c;
    assign sub = {disp_attr[3:1], disp_char[6:0]};
    assign idx = {slice_index[3:1], 1'b0} + {3'h0, pixel_col >= 3'h3};
    assign nib_go = nibble_code_transfer_cmd && long_mode && !xfer_busy;
    assign byte_go = byte_code_transfer_cmd && !(nibble_code_transfer_cmd && long_mode)
        && !xfer_busy;
    assign plain = !ul_cursor && !comp_cursor && !insert_mode;
    assign plain_c = glyph_bit ? base_fg : base_bg;
    assign neg_c = glyph_bit ? base_bg : base_fg;
    assign mos_c = sub[idx] ? base_fg : base_bg;
    a_sel_decode:
        assert property (chip_selected == (latched_addr.auto_select_nibble == SELECT_NIB
            && !latched_addr.cs_n)) else $error("select decode wrong");
    a_latch_quiet:
        assert property (!addr_latch_strobe [*8] |-> $stable(latched_addr))
        else $error("latch moved without strobe fall");
    a_latch_take:
        assert property ($fell(addr_latch_strobe) |-> ##8 latched_addr == $past({cs_n, ad_in}, 8))
        else $error("latched address wrong");
    a_glyph_map:
        assert property ($past(rst_n) |-> glyph_index_q == 7'($past(disp_char)))
        else $error("glyph index wrong");
    a_byte_len:
        assert property (byte_go |-> ##1 (xfer_busy && !xfer_done) [*2] ##1 xfer_done)
        else $error("byte transfer timing wrong");
    a_nib_read:
        assert property (nib_go && !xfer_write
            |-> ##1 (xfer_busy && !xfer_done) [*3] ##1 xfer_done)
        else $error("nibble read timing wrong");
    a_nib_write:
        assert property (nib_go && xfer_write |-> ##5 xfer_done)
        else $error("nibble write timing wrong");
    a_nib_refused:
        assert property (nibble_code_transfer_cmd && !long_mode && !byte_code_transfer_cmd
            && !xfer_busy |=> !xfer_busy) else $error("nibble command taken in short mode");
    a_pos_step:
        assert property (xfer_done && auto_inc && !pos_load
            |=> pos_q == (($past(pos_q) == POS_LAST) ? 7'h00 : $past(pos_q) + 7'h01))
        else $error("position step wrong");
    a_ul_slice:
        assert property (long_mode && !disp_char[7] && disp_attr == 4'h1
            && slice_index == LAST_SLICE && !comp_cursor && !insert_mode
            |=> pixel_color_q == $past(base_fg))
        else $error("underline slice wrong");
    a_short_plain:
        assert property (!long_mode && !disp_char[7] && plain |=> pixel_color_q == $past(plain_c))
        else $error("short code colour wrong");
    a_mosaic_sub:
        assert property (long_mode && disp_char[7] && !disp_attr[0] && plain
            |=> pixel_color_q == $past(mos_c)) else $error("mosaic sub-window wrong");
    a_neg_swap:
        assert property (long_mode && !disp_char[7] && disp_attr == 4'h4 && plain
            |=> pixel_color_q == $past(neg_c)) else $error("negative swap wrong");
    c_byte: cover property (byte_go);
    c_nib_wr: cover property (nib_go && xfer_write);
    c_select: cover property ($fell(addr_latch_strobe) ##8 chip_selected);
endmodule : ecc_core_assertions
bind ecc_core ecc_core_assertions i_chk (.*);
`default_nettype wire

// ---- verif/ecc_core_bench.sv ----
// self-checking bench for the eighty-column code block
`timescale 1ns/10ps
`default_nettype none
module ecc_core_bench
    import ecc_pkg::*;
;
    // ----------------------------------------
    // stimulus and checking
    // ----------------------------------------
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic addr_latch_strobe, cs_n, chip_selected, xfer_busy, xfer_done;
    logic [7:0] ad_in, rd_first_q, rd_third_q;
    ecc_addr_type latched_addr;
    logic long_mode = 1'b1, auto_inc = 1'b1, pos_load = 1'b0, xfer_write = 1'b0;
    logic nibble_code_transfer_cmd = 1'b0, byte_code_transfer_cmd = 1'b0;
    logic [6:0] pos_in = 7'h00, pos_q, glyph_index_q;
    logic [7:0] data_reg_first = 8'h00, data_reg_third = 8'h00, disp_char = 8'h00;
    logic [3:0] disp_attr = 4'h0, slice_index = 4'h0, margin_color = 4'h0;
    logic [3:0] base_fg = 4'h0, base_bg = 4'h0, pixel_color_q;
    logic [2:0] pixel_col = 3'h0;
    logic glyph_bit = 1'b0, ul_cursor = 1'b0, comp_cursor = 1'b0, insert_mode = 1'b0;
    ecc_origin_type char_set_origin_reg = 16'h0000;
    int err_total = 0;
    int comparisons = 0;
    int pos = 0;
    logic [31:0] seed = 32'h000154a6;
    logic [31:0] r;
    logic live = 1'b0;
    logic [7:0] mem [128];

    always #20 ref_clk = ~ref_clk;
    ecc_core i_dut (.*);
    ecc_host_model i_host (.*);

    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // attribute chain model; flash phase stays low within this run
    function automatic logic [3:0] pix_model();
        logic [3:0] at, f, g, t;
        logic [9:0] mb;
        logic mos, on;
        int k;
        at = long_mode ? disp_attr : 4'h0;
        mos = long_mode && disp_char[7];
        mb = {at[3:1], disp_char[6:0]};
        k = (slice_index / 2) * 2 + ((pixel_col > 2) ? 1 : 0);
        on = mos ? mb[k] : glyph_bit;
        f = base_fg;
        g = base_bg;
        if (((at[0] && !mos) || ul_cursor) && slice_index == LAST_SLICE)
            on = 1'b1;
        if (at[1] && at[2] && !mos)
            on = 1'b0;
        if (mos && at[0])
        begin
            g = margin_color;
            f = disp_char[6] ? char_set_origin_reg.fg_b : char_set_origin_reg.fg_a;
        end
        t = f;
        if (comp_cursor)
        begin
            f = ~f;
            g = ~g;
        end
        else if (at[2] && !mos)
        begin
            f = g;
            g = t;
        end
        t = on ? f : g;
        if (insert_mode && !mos)
            t = at[3] ? char_set_origin_reg.ins_b : char_set_origin_reg.ins_a;
        return t;
    endfunction : pix_model

    always @(negedge ref_clk)
    begin
        if (rst_n && live)
        begin
            cmp_data("pixel", {4'h0, pix_model()}, {4'h0, pixel_color_q});
            cmp_data("glyph", {1'b0, disp_char[6:0]}, {1'b0, glyph_index_q});
        end
        live = rst_n;
        r = rnd();
        disp_char <= r[7:0];
        disp_attr <= r[11:8];
        slice_index <= 4'(r[15:12] % 4'ha);
        pixel_col <= 3'(r[18:16] % 3'h6);
        glyph_bit <= r[19];
        ul_cursor <= r[20];
        comp_cursor <= &r[23:21];
        insert_mode <= &r[26:24];
        base_fg <= r[30:27];
        r = rnd();
        base_bg <= r[3:0];
        margin_color <= r[7:4];
        char_set_origin_reg <= r[23:8];
    end

    task complete_run;
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : complete_run

    task cmp_data(input string n, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : cmp_data

    task cmp_addr(input string n, input logic [8:0] e, input logic [8:0] g);
        comparisons++;
        if (g !== e)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : cmp_addr

    task wait_done;
        int i;
        i = 0;
        while (xfer_done !== 1'b1 && i < 20)
        begin
            @(negedge ref_clk);
            i++;
        end
        if (i == 20)
        begin
            err_total++;
            complete_run();
        end
    endtask : wait_done

    task load(input int p);
        @(negedge ref_clk);
        pos_in <= 7'(p);
        pos_load <= 1'b1;
        @(negedge ref_clk);
        pos_load <= 1'b0;
        pos = p;
    endtask : load

    task xfer(input logic nib, input logic wr, input logic [7:0] c, input logic [3:0] a);
        int ca;
        int na;
        ca = (pos % 2) * 40 + pos / 2;
        na = 80 + pos / 2;
        @(negedge ref_clk);
        nibble_code_transfer_cmd <= nib;
        byte_code_transfer_cmd <= !nib;
        xfer_write <= wr;
        data_reg_first <= c;
        data_reg_third <= {4'h0, a};
        @(negedge ref_clk);
        nibble_code_transfer_cmd <= 1'b0;
        byte_code_transfer_cmd <= 1'b0;
        wait_done();
        if (wr)
        begin
            mem[ca] = c;
            if (nib && pos % 2)
                mem[na][7:4] = a;
            else if (nib)
                mem[na][3:0] = a;
        end
        else
        begin
            cmp_data("char", mem[ca], rd_first_q);
            if (nib)
                cmp_data("nibble", {4'h0, pos % 2 ? mem[na][7:4] : mem[na][3:0]}, rd_third_q);
            else
                cmp_data("nibble", 8'h00, rd_third_q);
        end
        if (auto_inc)
            pos = (pos == 79) ? 0 : pos + 1;
        @(negedge ref_clk);
        cmp_data("pos", 8'(pos), {1'b0, pos_q});
    endtask : xfer

    initial
    begin
        logic [31:0] s;
        logic [7:0] b;
        repeat (10) @(negedge ref_clk);
        rst_n = 1'b1;
        @(negedge ref_clk);
        cmp_addr("addr_reset", 9'h100, latched_addr);
        repeat (8)
        begin
            s = rnd();
            b = s[0] ? {SELECT_NIB, s[4:1]} : s[12:5];
            i_host.bus_cycle(b, s[13]);
            cmp_addr("addr", {s[13], b}, latched_addr);
            cmp_data("select", {7'h0, b[7:4] == SELECT_NIB && !s[13]}, {7'h0, chip_selected});
        end
        for (int m = 1; m >= 0; m--)
        begin
            long_mode <= m[0];
            auto_inc <= 1'b1;
            load(78);
            repeat (4)
            begin
                s = rnd();
                xfer(m[0], 1'b1, s[7:0], s[11:8]);
            end
            load(78);
            repeat (4) xfer(m[0], 1'b0, 8'h00, 4'h0);
            repeat (6)
            begin
                s = rnd();
                auto_inc <= s[20];
                load(int'(s % 80));
                xfer(m[0], 1'b1, s[15:8], s[19:16]);
                load(int'(s % 80));
                xfer(m[0], 1'b0, 8'h00, 4'h0);
            end
            repeat (3000) @(negedge ref_clk);
        end
        nibble_code_transfer_cmd <= 1'b1;
        @(negedge ref_clk);
        nibble_code_transfer_cmd <= 1'b0;
        repeat (3)
        begin
            @(negedge ref_clk);
            cmp_data("refused", 8'h00, {7'h0, xfer_busy});
        end
        complete_run();
    end
endmodule : ecc_core_bench
`default_nettype wire

// ---- verif/ecc_host_model.sv ----
// host model driving the address phase pins
`timescale 1ns/10ps
`default_nettype none
module ecc_host_model
(
    input wire logic ref_clk,
    output logic addr_latch_strobe,
    output logic [7:0] ad_in,
    output logic cs_n
);
    initial
    begin
        addr_latch_strobe = 1'b0;
        ad_in = 8'h00;
        cs_n = 1'b1;
    end
    task bus_cycle(input logic [7:0] a, input logic c);
        @(negedge ref_clk);
        ad_in <= a;
        cs_n <= c;
        addr_latch_strobe <= 1'b1;
        repeat (4) @(negedge ref_clk);
        addr_latch_strobe <= 1'b0;
        repeat (4) @(negedge ref_clk);
        ad_in <= ~a;
        cs_n <= 1'b1;
    endtask : bus_cycle
endmodule : ecc_host_model
`default_nettype wire
